// ===== design/circular_interp_pulse_gen.sv
// Contract
// - target, pass and centre coordinates are signed 24-bit pulse counts on each axis.
// - in stop mode both axes cease pulsing once the target is reached.
// - in continue mode a target loaded before arrival starts the next arc without a stop.
// - in centre-point method the rotation sense is selectable as clockwise or counterclockwise; pass-point method takes it from the point order.
// - in pass-point method the arc runs through current position, pass point and target.
// - in centre-point method the arc is set by current position, centre and target.
// - x rate is speed times |y offset| over radius, y rate is speed times |x offset| over radius.
// - a circular status flag lets software see when the arc has completed.
// - the first pulse channel is the x axis and the second channel is the y axis.
// - pulsing stops at once when the execution condition is removed.
`timescale 1ns/1ps
`default_nettype none

module circular_interp_pulse_gen (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [7:0]              paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic                         irq,
	output circ_interp_pkg::axis_out_t   x_pulse_channel,
	output circ_interp_pkg::axis_out_t   y_pulse_channel,
	output logic                         x_channel_busy_flag,
	output logic                         y_channel_busy_flag,
	output logic                         circle_active_flag
);

	circ_interp_pkg::state_vec_t st_ff;
	circ_interp_pkg::state_vec_t nxt_st;

	logic signed [circ_interp_pkg::DIFF_W-1:0] ax;
	logic signed [circ_interp_pkg::DIFF_W-1:0] ay;
	logic signed [circ_interp_pkg::DIFF_W-1:0] bx;
	logic signed [circ_interp_pkg::DIFF_W-1:0] by;
	logic signed [circ_interp_pkg::SQ_W-1:0]   a2;
	logic signed [circ_interp_pkg::SQ_W-1:0]   b2;
	logic signed [circ_interp_pkg::NUM_W-1:0]  num_u;
	logic signed [circ_interp_pkg::NUM_W-1:0]  num_v;
	logic signed [circ_interp_pkg::DEN_W-1:0]  den;
	logic [circ_interp_pkg::NUM_W-1:0]         den_mag;
	logic signed [circ_interp_pkg::OFF_W-1:0]  ox;
	logic signed [circ_interp_pkg::OFF_W-1:0]  oy;
	logic [circ_interp_pkg::NUM_W-1:0]         mox;
	logic [circ_interp_pkg::NUM_W-1:0]         moy;
	logic [circ_interp_pkg::R2_W-1:0]          r2;
	logic [circ_interp_pkg::ACC_W-1:0]         thr;
	logic [circ_interp_pkg::ACC_W-1:0]         x_component_freq;
	logic [circ_interp_pkg::ACC_W-1:0]         y_component_freq;
	logic [circ_interp_pkg::ACC_W-1:0]         sum_x;
	logic [circ_interp_pkg::ACC_W-1:0]         sum_y;
	logic signed [circ_interp_pkg::DIFF_W-1:0] ex;
	logic signed [circ_interp_pkg::DIFF_W-1:0] ey;
	logic                                      near;
	logic [circ_interp_pkg::DEN_W:0]           rem_s;
	logic                                      div_ge;
	logic signed [circ_interp_pkg::CEN_W-1:0]  quot;
	logic [circ_interp_pkg::SQR_W-1:0]         sq_s;
	logic [circ_interp_pkg::SQR_W-1:0]         sq_trial;
	logic                                      sq_ge;
	logic                                      step_x_pos;
	logic                                      step_y_pos;
	logic                                      acc_phase;
	logic                                      wr;
	logic                                      go;
	logic [1:0]                                ev;
	logic [1:0]                                w1c;
	logic [31:0]                               rd_data;
	logic                                      rd_err;

	function automatic logic [circ_interp_pkg::NUM_W-1:0] mag(
		input logic signed [circ_interp_pkg::NUM_W-1:0] v
	);
		return v[circ_interp_pkg::NUM_W-1] ? circ_interp_pkg::NUM_W'(-v) : v;
	endfunction

	// ***************************************************************
	// arc geometry, relative to the current position, with the ox/oy offsets taken from the centre
	// ***************************************************************
	always_comb begin
		ax = circ_interp_pkg::DIFF_W'(st_ff.aux_x) - circ_interp_pkg::DIFF_W'(st_ff.pos_x);
		ay = circ_interp_pkg::DIFF_W'(st_ff.aux_y) - circ_interp_pkg::DIFF_W'(st_ff.pos_y);
		bx = circ_interp_pkg::DIFF_W'(st_ff.wtx) - circ_interp_pkg::DIFF_W'(st_ff.pos_x);
		by = circ_interp_pkg::DIFF_W'(st_ff.wty) - circ_interp_pkg::DIFF_W'(st_ff.pos_y);
		a2 = circ_interp_pkg::SQ_W'(ax) * circ_interp_pkg::SQ_W'(ax)
			+ circ_interp_pkg::SQ_W'(ay) * circ_interp_pkg::SQ_W'(ay);
		b2 = circ_interp_pkg::SQ_W'(bx) * circ_interp_pkg::SQ_W'(bx)
			+ circ_interp_pkg::SQ_W'(by) * circ_interp_pkg::SQ_W'(by);
		// circumcentre of start, pass and target: offset = num / den
		num_u = circ_interp_pkg::NUM_W'(by) * circ_interp_pkg::NUM_W'(a2)
			- circ_interp_pkg::NUM_W'(ay) * circ_interp_pkg::NUM_W'(b2);
		num_v = circ_interp_pkg::NUM_W'(ax) * circ_interp_pkg::NUM_W'(b2)
			- circ_interp_pkg::NUM_W'(bx) * circ_interp_pkg::NUM_W'(a2);
		den = (circ_interp_pkg::DEN_W'(ax) * circ_interp_pkg::DEN_W'(by)
			- circ_interp_pkg::DEN_W'(ay) * circ_interp_pkg::DEN_W'(bx)) <<< 1;
		den_mag = mag(circ_interp_pkg::NUM_W'(den));
		ox = circ_interp_pkg::OFF_W'(st_ff.pos_x) - circ_interp_pkg::OFF_W'(st_ff.cx);
		oy = circ_interp_pkg::OFF_W'(st_ff.pos_y) - circ_interp_pkg::OFF_W'(st_ff.cy);
		mox = mag(circ_interp_pkg::NUM_W'(ox));
		moy = mag(circ_interp_pkg::NUM_W'(oy));
		r2 = circ_interp_pkg::R2_W'(mox) * circ_interp_pkg::R2_W'(mox)
			+ circ_interp_pkg::R2_W'(moy) * circ_interp_pkg::R2_W'(moy);
		// rates compared against radius times clock avoid a divide per step
		thr = circ_interp_pkg::ACC_W'(st_ff.rad) * circ_interp_pkg::ACC_W'(circ_interp_pkg::CLK_HZ);
		x_component_freq = circ_interp_pkg::ACC_W'(st_ff.composite_speed)
			* circ_interp_pkg::ACC_W'(moy);
		y_component_freq = circ_interp_pkg::ACC_W'(st_ff.composite_speed)
			* circ_interp_pkg::ACC_W'(mox);
		sum_x = st_ff.acc_x + x_component_freq;
		sum_y = st_ff.acc_y + y_component_freq;
		ex = circ_interp_pkg::DIFF_W'(st_ff.pos_x) - circ_interp_pkg::DIFF_W'(st_ff.wtx);
		ey = circ_interp_pkg::DIFF_W'(st_ff.pos_y) - circ_interp_pkg::DIFF_W'(st_ff.wty);
		// the stepped path may pass the target diagonally, so one pulse of slack
		near = (ex >= -26'sh1) && (ex <= 26'sh1) && (ey >= -26'sh1) && (ey <= 26'sh1);
		// tangent direction: counterclockwise moves along (-oy, +ox)
		step_x_pos = st_ff.dir_ccw ? oy[circ_interp_pkg::OFF_W-1] : (oy > 29'sh0);
		step_y_pos = st_ff.dir_ccw ? (ox > 29'sh0) : ox[circ_interp_pkg::OFF_W-1];
		rem_s = {st_ff.rem[circ_interp_pkg::DEN_W-1:0], st_ff.dn[circ_interp_pkg::NUM_W-1]};
		div_ge = rem_s >= circ_interp_pkg::DEN_W'(den_mag) + 55'h0;
		quot = st_ff.sgn ? -signed'(st_ff.dn[circ_interp_pkg::CEN_W-1:0])
			: signed'(st_ff.dn[circ_interp_pkg::CEN_W-1:0]);
		sq_s = {st_ff.sq_rem[circ_interp_pkg::SQR_W-3:0],
			st_ff.sq_val[circ_interp_pkg::R2_W-1 -: 2]};
		sq_trial = {1'b0, st_ff.sq_root, 2'b01};
		sq_ge = sq_s >= sq_trial;
	end

	// ***************************************************************
	// apb decode
	// ***************************************************************
	always_comb begin
		acc_phase = psel && penable && st_ff.pready;
		wr = acc_phase && pwrite;
		go = wr && (paddr == circ_interp_pkg::ADDR_CTRL) && pwdata[circ_interp_pkg::CTRL_START]
			&& pwdata[circ_interp_pkg::CTRL_RUN];
		w1c = (wr && (paddr == circ_interp_pkg::ADDR_IRQ_STAT)) ? pwdata[1:0] : 2'h0;
		rd_err = 1'b0;
		if (paddr == circ_interp_pkg::ADDR_CTRL) begin
			rd_data = {27'h0, st_ff.ccw, st_ff.ctr, st_ff.cont, 1'b0, st_ff.run};
		end else if (paddr == circ_interp_pkg::ADDR_SPEED) begin
			rd_data = {17'h0, st_ff.composite_speed};
		end else if (paddr == circ_interp_pkg::ADDR_TGT_X) begin
			rd_data = 32'(st_ff.tgt_x);
		end else if (paddr == circ_interp_pkg::ADDR_TGT_Y) begin
			rd_data = 32'(st_ff.tgt_y);
		end else if (paddr == circ_interp_pkg::ADDR_AUX_X) begin
			rd_data = 32'(st_ff.aux_x);
		end else if (paddr == circ_interp_pkg::ADDR_AUX_Y) begin
			rd_data = 32'(st_ff.aux_y);
		end else if (paddr == circ_interp_pkg::ADDR_POS_X) begin
			rd_data = 32'(st_ff.pos_x);
		end else if (paddr == circ_interp_pkg::ADDR_POS_Y) begin
			rd_data = 32'(st_ff.pos_y);
		end else if (paddr == circ_interp_pkg::ADDR_STATUS) begin
			rd_data = {27'h0, st_ff.dir_ccw, st_ff.pend, st_ff.busy, st_ff.busy, st_ff.active};
			rd_err = pwrite;
		end else if (paddr == circ_interp_pkg::ADDR_IRQ_STAT) begin
			rd_data = {30'h0, st_ff.irq_stat};
		end else if (paddr == circ_interp_pkg::ADDR_IRQ_MASK) begin
			rd_data = {30'h0, st_ff.irq_mask};
		end else if (paddr == circ_interp_pkg::ADDR_RADIUS) begin
			rd_data = {3'h0, st_ff.rad};
			rd_err = pwrite;
		end else begin
			rd_data = 32'h0;
			rd_err = 1'b1;
		end
	end

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		nxt_st = st_ff;
		ev = 2'h0;
		nxt_st.x_out.pulse = 1'b0;
		nxt_st.y_out.pulse = 1'b0;
		nxt_st.pready = psel && !penable;
		nxt_st.pslverr = psel && !penable && rd_err;
		nxt_st.prdata = (psel && !penable && !pwrite) ? rd_data : 32'h0;
		if (!st_ff.run && (st_ff.state != circ_interp_pkg::ST_IDLE)) begin
			nxt_st.state = circ_interp_pkg::ST_IDLE;
			ev[circ_interp_pkg::IRQ_FAULT] = 1'b1;
		end else begin
			case (st_ff.state)
				circ_interp_pkg::ST_IDLE: begin
					if (go) begin
						nxt_st.wtx = st_ff.tgt_x;
						nxt_st.wty = st_ff.tgt_y;
						nxt_st.pend = 1'b0;
						nxt_st.state = circ_interp_pkg::ST_PREP;
					end
				end
				circ_interp_pkg::ST_PREP: begin
					nxt_st.cnt = circ_interp_pkg::DIV_STEPS;
					nxt_st.rem = '0;
					if (st_ff.ctr) begin
						nxt_st.cx = circ_interp_pkg::CEN_W'(st_ff.aux_x);
						nxt_st.cy = circ_interp_pkg::CEN_W'(st_ff.aux_y);
						nxt_st.dir_ccw = st_ff.ccw;
						nxt_st.cnt = circ_interp_pkg::ROOT_LOAD;
						nxt_st.state = circ_interp_pkg::ST_ROOT;
					end else if (den == '0) begin
						// collinear points describe no circle
						ev[circ_interp_pkg::IRQ_FAULT] = 1'b1;
						nxt_st.state = circ_interp_pkg::ST_IDLE;
					end else begin
						// sense follows the order start, pass, target
						nxt_st.dir_ccw = !den[circ_interp_pkg::DEN_W-1];
						nxt_st.dn = mag(num_u);
						nxt_st.sgn = num_u[circ_interp_pkg::NUM_W-1] ^ den[circ_interp_pkg::DEN_W-1];
						nxt_st.state = circ_interp_pkg::ST_DIVU;
					end
				end
				circ_interp_pkg::ST_DIVU, circ_interp_pkg::ST_DIVV: begin
					if (st_ff.cnt != 7'h0) begin
						nxt_st.rem = div_ge ? rem_s - (circ_interp_pkg::DEN_W'(den_mag) + 55'h0) : rem_s;
						nxt_st.dn = {st_ff.dn[circ_interp_pkg::NUM_W-2:0], div_ge};
						nxt_st.cnt = st_ff.cnt - 7'h1;
					end else if (st_ff.state == circ_interp_pkg::ST_DIVU) begin
						nxt_st.cx = circ_interp_pkg::CEN_W'(st_ff.pos_x) + quot;
						nxt_st.dn = mag(num_v);
						nxt_st.sgn = num_v[circ_interp_pkg::NUM_W-1] ^ den[circ_interp_pkg::DEN_W-1];
						nxt_st.rem = '0;
						nxt_st.cnt = circ_interp_pkg::DIV_STEPS;
						nxt_st.state = circ_interp_pkg::ST_DIVV;
					end else begin
						nxt_st.cy = circ_interp_pkg::CEN_W'(st_ff.pos_y) + quot;
						nxt_st.cnt = circ_interp_pkg::ROOT_LOAD;
						nxt_st.state = circ_interp_pkg::ST_ROOT;
					end
				end
				circ_interp_pkg::ST_ROOT: begin
					if (st_ff.cnt == circ_interp_pkg::ROOT_LOAD) begin
						nxt_st.sq_val = r2;
						nxt_st.sq_rem = '0;
						nxt_st.sq_root = '0;
						nxt_st.cnt = circ_interp_pkg::ROOT_STEPS;
					end else if (st_ff.cnt != 7'h0) begin
						nxt_st.sq_rem = sq_ge ? sq_s - sq_trial : sq_s;
						nxt_st.sq_root = {st_ff.sq_root[circ_interp_pkg::RAD_W-2:0], sq_ge};
						nxt_st.sq_val = {st_ff.sq_val[circ_interp_pkg::R2_W-3:0], 2'b00};
						nxt_st.cnt = st_ff.cnt - 7'h1;
					end else if (st_ff.sq_root == '0) begin
						ev[circ_interp_pkg::IRQ_FAULT] = 1'b1;
						nxt_st.state = circ_interp_pkg::ST_IDLE;
					end else begin
						nxt_st.rad = st_ff.sq_root;
						nxt_st.acc_x = '0;
						nxt_st.acc_y = '0;
						nxt_st.far = 1'b0;
						nxt_st.state = circ_interp_pkg::ST_RUN;
					end
				end
				circ_interp_pkg::ST_RUN: begin
					if (near && st_ff.far) begin
						ev[circ_interp_pkg::IRQ_DONE] = 1'b1;
						if (st_ff.cont && st_ff.pend) begin
							nxt_st.wtx = st_ff.tgt_x;
							nxt_st.wty = st_ff.tgt_y;
							nxt_st.pend = 1'b0;
							nxt_st.state = circ_interp_pkg::ST_PREP;
						end else begin
							nxt_st.state = circ_interp_pkg::ST_IDLE;
						end
					end else begin
						nxt_st.far = st_ff.far || !near;
						nxt_st.acc_x = (sum_x >= thr) ? sum_x - thr : sum_x;
						nxt_st.acc_y = (sum_y >= thr) ? sum_y - thr : sum_y;
						if (sum_x >= thr) begin
							nxt_st.x_out.pulse = 1'b1;
							nxt_st.x_out.dir = step_x_pos;
							nxt_st.pos_x = step_x_pos ? st_ff.pos_x + 24'sh1 : st_ff.pos_x - 24'sh1;
						end
						if (sum_y >= thr) begin
							nxt_st.y_out.pulse = 1'b1;
							nxt_st.y_out.dir = step_y_pos;
							nxt_st.pos_y = step_y_pos ? st_ff.pos_y + 24'sh1 : st_ff.pos_y - 24'sh1;
						end
					end
				end
				default: begin
					nxt_st.state = circ_interp_pkg::ST_IDLE;
				end
			endcase
		end
		// register writes come last so that a new target wins over consumption
		if (wr) begin
			if (paddr == circ_interp_pkg::ADDR_CTRL) begin
				nxt_st.run = pwdata[circ_interp_pkg::CTRL_RUN];
				nxt_st.cont = pwdata[circ_interp_pkg::CTRL_CONT];
				nxt_st.ctr = pwdata[circ_interp_pkg::CTRL_CENTRE];
				nxt_st.ccw = pwdata[circ_interp_pkg::CTRL_CCW];
			end else if (paddr == circ_interp_pkg::ADDR_SPEED) begin
				nxt_st.composite_speed = pwdata[circ_interp_pkg::SPD_W-1:0];
			end else if (paddr == circ_interp_pkg::ADDR_TGT_X) begin
				nxt_st.tgt_x = pwdata[circ_interp_pkg::COORD_W-1:0];
			end else if (paddr == circ_interp_pkg::ADDR_TGT_Y) begin
				nxt_st.tgt_y = pwdata[circ_interp_pkg::COORD_W-1:0];
				nxt_st.pend = st_ff.state != circ_interp_pkg::ST_IDLE;
			end else if (paddr == circ_interp_pkg::ADDR_AUX_X) begin
				nxt_st.aux_x = pwdata[circ_interp_pkg::COORD_W-1:0];
			end else if (paddr == circ_interp_pkg::ADDR_AUX_Y) begin
				nxt_st.aux_y = pwdata[circ_interp_pkg::COORD_W-1:0];
			end else if (paddr == circ_interp_pkg::ADDR_POS_X && st_ff.state == circ_interp_pkg::ST_IDLE) begin
				nxt_st.pos_x = pwdata[circ_interp_pkg::COORD_W-1:0];
			end else if (paddr == circ_interp_pkg::ADDR_POS_Y && st_ff.state == circ_interp_pkg::ST_IDLE) begin
				nxt_st.pos_y = pwdata[circ_interp_pkg::COORD_W-1:0];
			end else if (paddr == circ_interp_pkg::ADDR_IRQ_MASK) begin
				nxt_st.irq_mask = pwdata[1:0];
			end
		end
		nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | ev;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
		nxt_st.active = nxt_st.state != circ_interp_pkg::ST_IDLE;
		nxt_st.busy = nxt_st.state == circ_interp_pkg::ST_RUN;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= circ_interp_pkg::STATE_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata              = st_ff.prdata;
	assign pready              = st_ff.pready;
	assign pslverr             = st_ff.pslverr;
	assign irq                 = st_ff.irq;
	assign x_pulse_channel     = st_ff.x_out;
	assign y_pulse_channel     = st_ff.y_out;
	assign x_channel_busy_flag = st_ff.busy;
	assign y_channel_busy_flag = st_ff.busy;
	assign circle_active_flag  = st_ff.active;

endmodule

`default_nettype wire

// ===== pkg/circ_interp_pkg.sv
`default_nettype none

package circ_interp_pkg;

	// ***************************************************************
	// clock and arithmetic widths
	// ***************************************************************
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam logic [26:0] CLK_HZ        = 27'(1000000000 / CLK_PERIOD_NS);
	localparam int          COORD_W       = 24;
	localparam int          DIFF_W        = 26;
	localparam int          SQ_W          = 54;
	localparam int          NUM_W         = 80;
	localparam int          DEN_W         = 54;
	localparam int          CEN_W         = 28;
	localparam int          OFF_W         = 29;
	localparam int          R2_W          = 58;
	localparam int          RAD_W         = 29;
	localparam int          SQR_W         = 32;
	localparam int          ACC_W         = 57;
	localparam int          SPD_W         = 15;
	localparam logic [6:0]  DIV_STEPS     = 7'h50;
	localparam logic [6:0]  ROOT_STEPS    = 7'h1d;
	localparam logic [6:0]  ROOT_LOAD     = 7'h1e;

	// ***************************************************************
	// register map (byte addresses) and field positions
	// ***************************************************************
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_SPEED     = 8'h04;
	localparam logic [7:0] ADDR_TGT_X     = 8'h08;
	localparam logic [7:0] ADDR_TGT_Y     = 8'h0c;
	localparam logic [7:0] ADDR_AUX_X     = 8'h10;
	localparam logic [7:0] ADDR_AUX_Y     = 8'h14;
	localparam logic [7:0] ADDR_POS_X     = 8'h18;
	localparam logic [7:0] ADDR_POS_Y     = 8'h1c;
	localparam logic [7:0] ADDR_STATUS    = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h28;
	localparam logic [7:0] ADDR_RADIUS    = 8'h2c;
	localparam int         CTRL_RUN       = 0;
	localparam int         CTRL_START     = 1;
	localparam int         CTRL_CONT      = 2;
	localparam int         CTRL_CENTRE    = 3;
	localparam int         CTRL_CCW       = 4;
	localparam int         IRQ_DONE       = 0;
	localparam int         IRQ_FAULT      = 1;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_PREP = 6'h02,
		ST_DIVU = 6'h04,
		ST_DIVV = 6'h08,
		ST_ROOT = 6'h10,
		ST_RUN  = 6'h20
	} state_t;

	typedef struct packed {
		logic pulse;
		logic dir;
	} axis_out_t;

	typedef struct packed {
		state_t                    state;
		logic                      run;
		logic                      cont;
		logic                      ctr;
		logic                      ccw;
		logic                      pend;
		logic                      dir_ccw;
		logic                      far;
		logic                      sgn;
		logic [SPD_W-1:0]          composite_speed;
		logic signed [COORD_W-1:0] tgt_x;
		logic signed [COORD_W-1:0] tgt_y;
		logic signed [COORD_W-1:0] aux_x;
		logic signed [COORD_W-1:0] aux_y;
		logic signed [COORD_W-1:0] pos_x;
		logic signed [COORD_W-1:0] pos_y;
		logic signed [COORD_W-1:0] wtx;
		logic signed [COORD_W-1:0] wty;
		logic signed [CEN_W-1:0]   cx;
		logic signed [CEN_W-1:0]   cy;
		logic [ACC_W-1:0]          acc_x;
		logic [ACC_W-1:0]          acc_y;
		logic [RAD_W-1:0]          rad;
		logic [NUM_W-1:0]          dn;
		logic [DEN_W:0]            rem;
		logic [R2_W-1:0]           sq_val;
		logic [SQR_W-1:0]          sq_rem;
		logic [RAD_W-1:0]          sq_root;
		logic [6:0]                cnt;
		logic [1:0]                irq_stat;
		logic [1:0]                irq_mask;
		logic                      irq;
		logic                      pready;
		logic                      pslverr;
		logic [31:0]               prdata;
		axis_out_t                 x_out;
		axis_out_t                 y_out;
		logic                      busy;
		logic                      active;
	} state_vec_t;

	localparam state_vec_t STATE_RESET = '{state: ST_IDLE, default: '0};

endpackage

`default_nettype wire

// ===== test/circ_props.sv
`timescale 1ns/1ps
`default_nettype none
module circ_props (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic [7:0]                 paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       irq,
	input wire circ_interp_pkg::axis_out_t x_pulse_channel,
	input wire circ_interp_pkg::axis_out_t y_pulse_channel,
	input wire logic                       x_channel_busy_flag,
	input wire logic                       y_channel_busy_flag,
	input wire logic                       circle_active_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
	a_pready_answer: assert property (psel && !penable |=> pready) else $error("no answer");
	a_pready_single: assert property (pready |=> !pready) else $error("pready held");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h2c |=> pslverr) else $error("no err");
	a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	a_busy_in_arc: assert property (x_channel_busy_flag |-> circle_active_flag) else $error("busy alone");
	a_x_pulse_busy: assert property (x_pulse_channel.pulse |-> x_channel_busy_flag) else $error("x pulse idle");
	a_y_pulse_busy: assert property (y_pulse_channel.pulse |-> y_channel_busy_flag) else $error("y pulse idle");
	a_pulse_single: assert property (x_pulse_channel.pulse |=> !x_pulse_channel.pulse) else $error("x pulse long");
	a_start_arc: assert property (ctrl_wr && pwdata[1:0] == 2'b11 && !circle_active_flag |=> circle_active_flag)
		else $error("start lost");
	a_run_abort: assert property (ctrl_wr && !pwdata[0] && circle_active_flag |-> ##[1:2] !circle_active_flag)
		else $error("abort lost");
	c_start: cover property (ctrl_wr && pwdata[1:0] == 2'b11);
	c_done: cover property ($fell(circle_active_flag));
	c_irq: cover property (irq);
endmodule
bind circular_interp_pulse_gen circ_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .x_pulse_channel(x_pulse_channel), .y_pulse_channel(y_pulse_channel),
	.x_channel_busy_flag(x_channel_busy_flag), .y_channel_busy_flag(y_channel_busy_flag),
	.circle_active_flag(circle_active_flag));
`default_nettype wire

// ===== test/motor_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_drive_model (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire circ_interp_pkg::axis_out_t x_drive,
	input wire circ_interp_pkg::axis_out_t y_drive,
	output logic signed [23:0]             x_steps,
	output logic signed [23:0]             y_steps
);
	// each drive counts one step per pulse, sign from the direction line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x_steps <= '0;
			y_steps <= '0;
		end else begin
			if (x_drive.pulse) x_steps <= x_steps + (x_drive.dir ? 24'sd1 : -24'sd1);
			if (y_drive.pulse) y_steps <= y_steps + (y_drive.dir ? 24'sd1 : -24'sd1);
		end
	end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic                       x_busy, y_busy, active;
	logic [7:0]                 paddr;
	logic [31:0]                pwdata, prdata, rnd;
	circ_interp_pkg::axis_out_t x_ch, y_ch;
	logic signed [23:0]         x_steps, y_steps, x0, y0;
	logic [32:0]                expect_q[$];
	int                         bad_count, samples_checked, k;
	circular_interp_pulse_gen dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .x_pulse_channel(x_ch), .y_pulse_channel(y_ch),
		.x_channel_busy_flag(x_busy), .y_channel_busy_flag(y_busy), .circle_active_flag(active));
	motor_drive_model drv_u (.pclk(pclk), .presetn(presetn), .x_drive(x_ch), .y_drive(y_ch),
		.x_steps(x_steps), .y_steps(y_steps));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ***************************************************************
	// bus master and result checking
	// ***************************************************************
	task chk(input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// a stepped arc may end one pulse off the exact target
	task near(input logic signed [23:0] g, input logic signed [23:0] e);
		samples_checked++;
		if (^g === 1'bx || g > e + 24'sd1 || g < e - 24'sd1) begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		expect_q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && expect_q.size() > 0) chk(expect_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
	end
	task wrap_up;
		$display("checks=%0d errors=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ***************************************************************
	// scenarios
	// ***************************************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		void'($urandom(32'h6af7));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		xfer(8'h00, 1'b0, 32'h0, 33'h0);
		xfer(8'h30, 1'b0, 32'h0, {1'b1, 32'h0});
		xfer(8'h20, 1'b1, 32'h1, {1'b1, 32'h0});
		rnd = $urandom();
		xfer(8'h08, 1'b1, rnd, 33'h0);
		xfer(8'h08, 1'b0, 32'h0, {1'b0, {8{rnd[23]}}, rnd[23:0]});
		xfer(8'h04, 1'b1, 32'h4e20, 33'h0);
		xfer(8'h28, 1'b1, 32'h1, 33'h0);
		for (k = 0; k < 2; k++) begin
			x0 = x_steps;
			y0 = y_steps;
			xfer(8'h18, 1'b1, k ? 32'h0 : 32'h2, 33'h0);
			xfer(8'h1c, 1'b1, k ? 32'h2 : 32'h0, 33'h0);
			xfer(8'h10, 1'b1, 32'h0, 33'h0);
			xfer(8'h14, 1'b1, 32'h0, 33'h0);
			xfer(8'h08, 1'b1, k ? 32'h2 : 32'h0, 33'h0);
			xfer(8'h0c, 1'b1, k ? 32'h0 : 32'h2, 33'h0);
			xfer(8'h00, 1'b1, k ? 32'h0b : 32'h1b, 33'h0);
			wait (active);
			wait (!active);
			// let the drive model count the last step before reading it
			@(posedge pclk);
			near(x_steps - x0, k ? 24'sd2 : -24'sd2);
			near(y_steps - y0, k ? -24'sd2 : 24'sd2);
			xfer(8'h2c, 1'b0, 32'h0, {1'b0, 32'h2});
			xfer(8'h24, 1'b0, 32'h0, {1'b0, 32'h1});
			chk(33'h1, {32'h0, irq});
			xfer(8'h24, 1'b1, 32'h1, 33'h0);
			repeat (3) @(posedge pclk);
			chk(33'h0, {32'h0, irq});
		end
		// pass-point arc in continue mode: a target queued mid-arc must not end it
		x0 = x_steps;
		y0 = y_steps;
		xfer(8'h18, 1'b1, 32'h2, 33'h0);
		xfer(8'h1c, 1'b1, 32'h1, 33'h0);
		xfer(8'h10, 1'b1, 32'h1, 33'h0);
		xfer(8'h14, 1'b1, 32'h2, 33'h0);
		xfer(8'h08, 1'b1, 32'hffffffff, 33'h0);
		xfer(8'h0c, 1'b1, 32'h2, 33'h0);
		xfer(8'h00, 1'b1, 32'h07, 33'h0);
		xfer(8'h0c, 1'b1, 32'h0, 33'h0);
		xfer(8'h20, 1'b0, 32'h0, {1'b0, 32'h19});
		wait (irq);
		@(posedge pclk);
		chk(33'h1, {32'h0, active});
		near(x_steps - x0, -24'sd3);
		near(y_steps - y0, 24'sd1);
		xfer(8'h00, 1'b1, 32'h0, 33'h0);
		xfer(8'h24, 1'b0, 32'h0, {1'b0, 32'h3});
		xfer(8'h24, 1'b1, 32'h3, 33'h0);
		xfer(8'h28, 1'b1, 32'h0, 33'h0);
		xfer(8'h00, 1'b1, 32'h1b, 33'h0);
		xfer(8'h00, 1'b1, 32'h0, 33'h0);
		repeat (3) @(posedge pclk);
		chk(33'h0, {31'h0, irq, active});
		xfer(8'h24, 1'b0, 32'h0, {1'b0, 32'h2});
		xfer(8'h28, 1'b1, 32'h2, 33'h0);
		repeat (3) @(posedge pclk);
		chk(33'h1, {32'h0, irq});
		xfer(8'h24, 1'b1, 32'h2, 33'h0);
		repeat (3) @(posedge pclk);
		chk(33'h0, {32'h0, irq});
		wrap_up;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		bad_count++;
		$display("ERROR t=%0t watchdog exp=%h got=%h", $time, 1'b0, 1'b1);
		wrap_up;
	end
endmodule
`default_nettype wire
